// file: memctl_evsel_pkg.sv
package memctl_evsel_pkg;

    localparam int DATA_W       = 32;
    localparam int STRB_W       = DATA_W / 8;
    localparam int ADDR_W       = 8;
    localparam int NUM_COUNTERS = 4;
    localparam int CTR_IDX_W    = 2;
    localparam int CTR_IDX_LSB  = 2;
    localparam int EV_CODE_W    = 8;
    localparam int QUAL_W       = 8;

    // counter control word layout
    localparam int CTL_CODE_LSB = 0;
    localparam int CTL_QUAL_LSB = 8;
    localparam int CTL_EN_BIT   = 22;
    localparam logic [DATA_W-1:0] CTL_WMASK = 32'h0040_FFFF;
    localparam logic [DATA_W-1:0] CTL_RESET = 32'h0000_0000;

    // event codes
    localparam logic [EV_CODE_W-1:0] EV_PREEMPT     = 8'h08;
    localparam logic [EV_CODE_W-1:0] EV_PRECHARGE   = 8'h02;
    localparam logic [EV_CODE_W-1:0] EV_CAS_PRIO    = 8'hA0;
    localparam logic [EV_CODE_W-1:0] EV_CAS_RANK_LO = 8'hB0;
    localparam logic [EV_CODE_W-1:0] EV_CAS_RANK_HI = 8'hB6;

    // qualifier bit positions; the precharge ones also index the cause vector
    localparam int Q_PAGE_MISS  = 0;
    localparam int Q_PAGE_CLOSE = 1;
    localparam int Q_BYPASS     = 4;
    localparam int PRE_CAUSE_W  = 5;
    localparam int Q_RD_OVER_RD = 0;
    localparam int Q_RD_OVER_WR = 1;
    localparam logic [1:0] PRIO_STARVED = 2'h3;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTL_BASE   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CNT_BASE   = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_INT_MASK   = 8'h24;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        REG_CTL, REG_CNT, REG_STATUS, REG_MASK, REG_NONE
    } region_t;

    function automatic region_t addr_region(input logic [ADDR_W-1:0] a);
        if (a < ADDR_CNT_BASE)
            return REG_CTL;
        if (a < ADDR_INT_STATUS)
            return REG_CNT;
        if (a[ADDR_W-1:CTR_IDX_LSB] == ADDR_INT_STATUS[ADDR_W-1:CTR_IDX_LSB])
            return REG_STATUS;
        if (a[ADDR_W-1:CTR_IDX_LSB] == ADDR_INT_MASK[ADDR_W-1:CTR_IDX_LSB])
            return REG_MASK;
        return REG_NONE;
    endfunction : addr_region

    function automatic logic [DATA_W-1:0] merge_bytes(
        input logic [DATA_W-1:0] old_word,
        input logic [DATA_W-1:0] new_word,
        input logic [STRB_W-1:0] strb
    );
        logic [DATA_W-1:0] res;
        res = old_word;
        for (int b = 0; b < STRB_W; b++) begin
            if (strb[b])
                res[b*8 +: 8] = new_word[b*8 +: 8];
        end
        return res;
    endfunction : merge_bytes

    function automatic logic is_rank_code(input logic [EV_CODE_W-1:0] c);
        return (c >= EV_CAS_RANK_LO) && (c <= EV_CAS_RANK_HI);
    endfunction : is_rank_code

endpackage : memctl_evsel_pkg

// file: memctl_event_match.sv
`timescale 1ns/1ps
module memctl_event_match
    import memctl_evsel_pkg::*;
(
    input  wire logic [EV_CODE_W-1:0]   event_code,
    input  wire logic [QUAL_W-1:0]      qual_mask,
    input  wire logic                   pre_valid,
    input  wire logic                   pre_auto,
    input  wire logic [PRE_CAUSE_W-1:0] pre_cause,
    input  wire logic                   read_over_read,
    input  wire logic                   read_over_write,
    input  wire logic                   cas_valid,
    input  wire logic [1:0]             cas_prio,
    input  wire logic [2:0]             cas_rank,
    input  wire logic [2:0]             cas_bank,
    output logic                        hit
);
    logic [PRE_CAUSE_W-1:0] cause_eff;
    logic [1:0]             preempt_vec;
    logic [2:0]             rank_sel;

    // auto-precharges never count as page miss or page close
    always_comb begin
        cause_eff = pre_cause;
        cause_eff[Q_PAGE_MISS]  = pre_cause[Q_PAGE_MISS] && !pre_auto;  // RULE_02
        cause_eff[Q_PAGE_CLOSE] = pre_cause[Q_PAGE_CLOSE] && !pre_auto; // RULE_03
    end

    always_comb begin
        preempt_vec = '0;
        preempt_vec[Q_RD_OVER_RD] = read_over_read;
        preempt_vec[Q_RD_OVER_WR] = read_over_write;
    end

    assign rank_sel = 3'(event_code - EV_CAS_RANK_LO);

    // one hit per cycle however many selected bits match
    always_comb begin
        hit = 1'b0;
        if (event_code == EV_PRECHARGE)
            hit = pre_valid && |(qual_mask[PRE_CAUSE_W-1:0] & cause_eff); // RULE_01 RULE_04 RULE_09
        else if (event_code == EV_PREEMPT)
            hit = |(qual_mask[1:0] & preempt_vec); // RULE_05
        else if (event_code == EV_CAS_PRIO)
            hit = cas_valid && qual_mask[cas_prio]; // RULE_06
        else if (is_rank_code(event_code))
            hit = cas_valid && (cas_rank == rank_sel) && qual_mask[cas_bank]; // RULE_07
    end

endmodule : memctl_event_match

// file: memctl_perf_counter.sv
`timescale 1ns/1ps
module memctl_perf_counter #(
    parameter int WIDTH = 32
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             enable,
    input  wire logic             hit,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic      [WIDTH-1:0] count,
    output logic                  wrap
);
    logic [WIDTH-1:0] count_reg;
    logic             wrap_reg;
    logic             bump;

    // a software load in the same cycle wins over a hit
    assign bump = enable && hit && !load;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            count_reg <= '0;
        else if (load)
            count_reg <= load_value;
        else if (bump)
            count_reg <= count_reg + WIDTH'(1); // RULE_08
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            wrap_reg <= 1'b0;
        else
            wrap_reg <= bump && (&count_reg);
    end

    assign count = count_reg;
    assign wrap  = wrap_reg;

endmodule : memctl_perf_counter

// file: memctl_event_selector.sv
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// RULE_01 - precharge code counts qualified channel precharges
// RULE_02 - bit 0: page-miss precharges, no auto-precharge
// RULE_03 - bit 1: page-close timer precharges, no auto
// RULE_04 - bits 2-4: read, write, bypass precharges
// RULE_05 - preempt bits: read over read, over write
// RULE_06 - priority bits: low, medium, high, starved
// RULE_07 - codes b0-b6: rank read CAS, bank per bit
// RULE_08 - at most one per cycle, counters 0-3
// RULE_09 - any selected match adds exactly one
module memctl_event_selector
    import memctl_evsel_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [DATA_W-1:0]      s_axi_wdata,
    input  wire logic [STRB_W-1:0]      s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [DATA_W-1:0]           s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic                        irq,
    input  wire logic                   pre_valid,
    input  wire logic                   pre_auto,
    input  wire logic [PRE_CAUSE_W-1:0] pre_cause,
    input  wire logic                   read_over_read,
    input  wire logic                   read_over_write,
    input  wire logic                   cas_valid,
    input  wire logic [1:0]             cas_prio,
    input  wire logic [2:0]             cas_rank,
    input  wire logic [2:0]             cas_bank
);

    logic [DATA_W-1:0]       ctl_reg [NUM_COUNTERS];
    logic [DATA_W-1:0]       cnt_val [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] hit_vec;
    logic [NUM_COUNTERS-1:0] wrap_vec;
    logic [NUM_COUNTERS-1:0] cnt_load;
    logic [NUM_COUNTERS-1:0] int_status_reg;
    logic [NUM_COUNTERS-1:0] int_status_next;
    logic [NUM_COUNTERS-1:0] int_mask_reg;
    logic [NUM_COUNTERS-1:0] status_clr;

    logic                    aw_held_reg;
    logic                    w_held_reg;
    logic [ADDR_W-1:0]       awaddr_reg;
    logic [DATA_W-1:0]       wdata_reg;
    logic [STRB_W-1:0]       wstrb_reg;
    logic                    awready_reg;
    logic                    wready_reg;
    logic                    bvalid_reg;
    logic [1:0]              bresp_reg;
    logic                    arready_reg;
    logic                    rvalid_reg;
    logic [DATA_W-1:0]       rdata_reg;
    logic [1:0]              rresp_reg;
    logic                    irq_reg;

    logic                    aw_take;
    logic                    w_take;
    logic                    ar_take;
    logic                    do_write;
    logic                    aw_held_next;
    logic                    w_held_next;
    logic                    bvalid_next;
    logic                    rvalid_next;
    region_t                 wr_region;
    region_t                 rd_region;
    logic [CTR_IDX_W-1:0]    wr_slot;
    logic [CTR_IDX_W-1:0]    rd_slot;
    logic [DATA_W-1:0]       rd_word;
    logic [1:0]              rd_resp;

    // ---------------- write channel ----------------
    assign aw_take   = s_axi_awvalid && awready_reg;
    assign w_take    = s_axi_wvalid && wready_reg;
    // address and data may arrive in either order; both are parked
    assign do_write  = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_region = addr_region(awaddr_reg);
    assign wr_slot   = awaddr_reg[CTR_IDX_LSB +: CTR_IDX_W];

    assign aw_held_next = aw_take || (aw_held_reg && !do_write);
    assign w_held_next  = w_take || (w_held_reg && !do_write);
    assign bvalid_next  = do_write || (bvalid_reg && !s_axi_bready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
        end else begin
            aw_held_reg <= aw_held_next;
            if (aw_take)
                awaddr_reg <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
        end else begin
            w_held_reg <= w_held_next;
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
        end
    end

    // ready drops while a beat is parked or a response is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
        end else begin
            awready_reg <= !aw_held_next && !bvalid_next;
            wready_reg  <= !w_held_next && !bvalid_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else begin
            bvalid_reg <= bvalid_next;
            if (do_write)
                bresp_reg <= (wr_region == REG_NONE) ? RESP_DECERR
                                                     : RESP_OKAY;
        end
    end

    // ---------------- register file ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_COUNTERS; i++)
                ctl_reg[i] <= CTL_RESET;
        end else if (do_write && wr_region == REG_CTL) begin
            ctl_reg[wr_slot] <= merge_bytes(ctl_reg[wr_slot], wdata_reg,
                                            wstrb_reg) & CTL_WMASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            int_mask_reg <= '0;
        else if (do_write && wr_region == REG_MASK && wstrb_reg[0])
            int_mask_reg <= wdata_reg[NUM_COUNTERS-1:0];
    end

    // write-one-to-clear; a wrap in the same cycle keeps its bit set
    always_comb begin
        status_clr = '0;
        if (do_write && wr_region == REG_STATUS && wstrb_reg[0])
            status_clr = wdata_reg[NUM_COUNTERS-1:0];
        int_status_next = (int_status_reg & ~status_clr) | wrap_vec;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            int_status_reg <= '0;
        else
            int_status_reg <= int_status_next;
    end

    // one cycle behind the status bit, so the pin is a clean flop
    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(int_status_reg & int_mask_reg);
    end

    // ---------------- event counters ----------------
    // only the four general counters can see these events
    for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_ctr
        assign cnt_load[i] = do_write && wr_region == REG_CNT
                             && wr_slot == CTR_IDX_W'(i); // RULE_08

        memctl_event_match u_match (
            .event_code      (ctl_reg[i][CTL_CODE_LSB +: EV_CODE_W]),
            .qual_mask       (ctl_reg[i][CTL_QUAL_LSB +: QUAL_W]),
            .pre_valid       (pre_valid),
            .pre_auto        (pre_auto),
            .pre_cause       (pre_cause),
            .read_over_read  (read_over_read),
            .read_over_write (read_over_write),
            .cas_valid       (cas_valid),
            .cas_prio        (cas_prio),
            .cas_rank        (cas_rank),
            .cas_bank        (cas_bank),
            .hit             (hit_vec[i])
        );

        memctl_perf_counter #(
            .WIDTH (DATA_W)
        ) u_cnt (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .enable     (ctl_reg[i][CTL_EN_BIT]),
            .hit        (hit_vec[i]),
            .load       (cnt_load[i]),
            .load_value (merge_bytes(cnt_val[i], wdata_reg, wstrb_reg)),
            .count      (cnt_val[i]),
            .wrap       (wrap_vec[i])
        );
    end

    // ---------------- read channel ----------------
    assign ar_take     = s_axi_arvalid && arready_reg;
    assign rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);
    assign rd_region   = addr_region(s_axi_araddr);
    assign rd_slot     = s_axi_araddr[CTR_IDX_LSB +: CTR_IDX_W];

    always_comb begin
        rd_word = '0;
        rd_resp = RESP_OKAY;
        unique case (rd_region)
            REG_CTL:    rd_word = ctl_reg[rd_slot];
            REG_CNT:    rd_word = cnt_val[rd_slot];
            REG_STATUS: rd_word = DATA_W'(int_status_reg);
            REG_MASK:   rd_word = DATA_W'(int_mask_reg);
            default:    rd_resp = RESP_DECERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else begin
            rvalid_reg  <= rvalid_next;
            arready_reg <= !rvalid_next;
            if (ar_take) begin
                rdata_reg <= rd_word;
                rresp_reg <= rd_resp;
            end
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq           = irq_reg;

    // ---------------- checks on counter 0 and the read channel ----------------
    logic [EV_CODE_W-1:0] code0;
    logic [QUAL_W-1:0]    qual0;
    logic                 en0;

    assign code0 = ctl_reg[0][CTL_CODE_LSB +: EV_CODE_W];
    assign qual0 = ctl_reg[0][CTL_QUAL_LSB +: QUAL_W];
    assign en0   = ctl_reg[0][CTL_EN_BIT];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_counted_hit;
        en0 && hit_vec[0] && !cnt_load[0];
    endsequence

    sequence s_count_plus_one;
        cnt_val[0] == $past(cnt_val[0]) + 32'h0000_0001;
    endsequence

    a_pre_needs_cmd: assert property ( // RULE_01
        (code0 == EV_PRECHARGE && !pre_valid) |-> !hit_vec[0])
        else $error("precharge hit without a precharge command");

    a_miss_skips_auto: assert property ( // RULE_02
        (code0 == EV_PRECHARGE && qual0[Q_PAGE_MISS]
         && qual0[PRE_CAUSE_W-1:Q_PAGE_CLOSE] == '0 && pre_auto)
        |-> !hit_vec[0])
        else $error("auto-precharge counted as page miss");

    a_close_counted: assert property ( // RULE_03
        (code0 == EV_PRECHARGE && qual0[Q_PAGE_CLOSE] && pre_valid
         && pre_cause[Q_PAGE_CLOSE] && !pre_auto) |-> hit_vec[0])
        else $error("page-close precharge not counted");

    a_bypass_only: assert property ( // RULE_04
        (code0 == EV_PRECHARGE
         && qual0[PRE_CAUSE_W-1:0] == PRE_CAUSE_W'(1 << Q_BYPASS))
        |-> hit_vec[0] == (pre_valid && pre_cause[Q_BYPASS]))
        else $error("bypass precharge selection wrong");

    a_preempt_write: assert property ( // RULE_05
        (code0 == EV_PREEMPT && qual0[1:0] == 2'h2)
        |-> hit_vec[0] == read_over_write)
        else $error("read over write preemption mismatch");

    a_starved_cas: assert property ( // RULE_06
        (code0 == EV_CAS_PRIO && cas_valid && cas_prio == PRIO_STARVED
         && qual0[PRIO_STARVED]) |-> hit_vec[0])
        else $error("starved read CAS not counted");

    a_rank_bank: assert property ( // RULE_07
        (is_rank_code(code0) && hit_vec[0])
        |-> (cas_valid && cas_rank == 3'(code0 - EV_CAS_RANK_LO)
             && qual0[cas_bank]))
        else $error("rank CAS hit on wrong rank or bank");

    a_count_by_one: assert property ( // RULE_08
        s_counted_hit |=> s_count_plus_one)
        else $error("counter did not step by one on a hit");

    a_any_match_one: assert property ( // RULE_09
        (code0 == EV_PRECHARGE && (&qual0[PRE_CAUSE_W-1:0]) && pre_valid
         && (&pre_cause[PRE_CAUSE_W-1:Q_BYPASS-2]) && en0
         && !cnt_load[0]) |=> s_count_plus_one)
        else $error("multiple matches not counted as one");

    a_read_answer: assert property (
        ar_take |=> (s_axi_rvalid && s_axi_rdata == $past(rd_word)))
        else $error("read answer not one cycle after address");

endmodule : memctl_event_selector

// file: memctl_sched_model.sv
`timescale 1ns/1ps
module memctl_sched_model
    import memctl_evsel_pkg::*;
(
    input  wire logic                   aclk,
    output logic                        pre_valid,
    output logic                        pre_auto,
    output logic [PRE_CAUSE_W-1:0]      pre_cause,
    output logic                        read_over_read,
    output logic                        read_over_write,
    output logic                        cas_valid,
    output logic [1:0]                  cas_prio,
    output logic [2:0]                  cas_rank,
    output logic [2:0]                  cas_bank
);
    initial begin
        {pre_valid, read_over_read, read_over_write, cas_valid} = '0;
        {pre_auto, pre_cause, cas_prio, cas_rank, cas_bank} = '0;
    end

    // kind 0 precharge, 1 read over read, 2 read over write, 3 read cas;
    // arg[4:0] cause, arg[7] auto, arg[1:0] priority, arg[6:4] bank;
    // the strobe stays up n cycles, one event per cycle
    task automatic issue(input int kind, input logic [7:0] arg,
                         input logic [2:0] rank, input int n);
        pre_valid <= (kind == 0);
        read_over_read <= (kind == 1);
        read_over_write <= (kind == 2);
        cas_valid <= (kind == 3);
        pre_auto <= arg[7];
        pre_cause <= arg[4:0];
        cas_prio <= arg[1:0];
        cas_bank <= arg[6:4];
        cas_rank <= rank;
        repeat (n) @(posedge aclk);
        {pre_valid, read_over_read, read_over_write, cas_valid} <= '0;
        // qualifiers flip once released so stale values never match
        pre_auto <= ~arg[7];
        pre_cause <= ~arg[4:0];
        cas_prio <= ~arg[1:0];
        cas_bank <= ~arg[6:4];
        cas_rank <= ~rank;
    endtask : issue
endmodule : memctl_sched_model

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top
    import memctl_evsel_pkg::*;
;
    logic aclk, aresetn, irq;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, v;
    logic [STRB_W-1:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic pre_valid, pre_auto, read_over_read, read_over_write;
    logic cas_valid;
    logic [PRE_CAUSE_W-1:0] pre_cause;
    logic [1:0] cas_prio;
    logic [2:0] cas_rank, cas_bank;
    int mismatches, n_compared, ci;

    memctl_event_selector memctl_event_selector_inst (.*);
    memctl_sched_model memctl_sched_model_inst (.*);

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] resp);
        int t;
        logic aw_done, w_done;
        @(posedge aclk);
        t = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done) && t < 64) begin
            @(posedge aclk);
            t++;
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
            t++;
        end while (s_axi_bvalid !== 1'b1 && t < 64);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (t >= 64) begin
            mismatches++;
            conclude();
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
        int t;
        @(posedge aclk);
        t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
        end while (s_axi_arready !== 1'b1 && t < 64);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            t++;
        end while (s_axi_rvalid !== 1'b1 && t < 64);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (t >= 64) begin
            mismatches++;
            conclude();
        end
    endtask : axi_rd

    // program a counter, fire n events, read the count back;
    // counters rotate so all four general counters are used
    task automatic trial(input logic [7:0] code, input logic [7:0] qual,
                         input int kind, input logic [7:0] arg,
                         input logic [2:0] rank, input int n,
                         input logic [31:0] exp);
        logic [7:0] off;
        off = 8'(4 * (ci % NUM_COUNTERS));
        ci++;
        axi_wr(ADDR_CTL_BASE + off, {16'h0040, qual, code}, r);
        axi_wr(ADDR_CNT_BASE + off, 32'h0000_0000, r);
        memctl_sched_model_inst.issue(kind, arg, rank, n);
        repeat (2) @(posedge aclk);
        axi_rd(ADDR_CNT_BASE + off, v, r);
        chk(v, exp);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask : trial

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values, write mask and an unmapped place
        axi_rd(ADDR_CTL_BASE, v, r);
        chk(v, CTL_RESET);
        axi_rd(ADDR_INT_STATUS, v, r);
        chk(v, 32'h0000_0000);
        axi_wr(ADDR_CTL_BASE + 8'h04, 32'hFFFF_FFFF, r);
        axi_rd(ADDR_CTL_BASE + 8'h04, v, r);
        chk(v, CTL_WMASK);
        axi_rd(8'h40, v, r);
        chk(v, 32'h0000_0000);
        chk({30'h0, r}, {30'h0, RESP_DECERR});
        axi_wr(8'h40, 32'h1234_5678, r);
        chk({30'h0, r}, {30'h0, RESP_DECERR});
        $display("test registers done");
        // counter 0 carries the checks, so key cases start there
        for (int b = 0; b < 5; b++) begin
            ci = 0;
            trial(EV_PRECHARGE, 8'(1 << b), 0, 8'(1 << b), 0, 1, 1);
            trial(EV_PRECHARGE, 8'(1 << b), 0, 8'(2 << b), 0, 1, 0);
        end
        ci = 0;
        trial(EV_PRECHARGE, 8'h01, 0, 8'h81, 0, 1, 0);
        trial(EV_PRECHARGE, 8'h02, 0, 8'h82, 0, 1, 0);
        ci = 0;
        trial(EV_PRECHARGE, 8'h1f, 0, 8'h1f, 0, 3, 3);
        trial(EV_PREEMPT, 8'h01, 1, 8'h00, 0, 1, 1);
        trial(EV_PREEMPT, 8'h01, 2, 8'h00, 0, 1, 0);
        ci = 0;
        trial(EV_PREEMPT, 8'h02, 2, 8'h00, 0, 2, 2);
        for (int p = 0; p < 4; p++) begin
            ci = 0;
            trial(EV_CAS_PRIO, 8'(1 << p), 3, 8'(p), 0, 1, 1);
            trial(EV_CAS_PRIO, 8'(1 << p), 3, 8'(p + 1), 0, 1, 0);
        end
        for (int k = 0; k < 7; k++) begin
            trial(EV_CAS_RANK_LO + 8'(k), 8'(1 << k), 3, 8'(k << 4),
                  3'(k), 1, 1);
            trial(EV_CAS_RANK_LO + 8'(k), 8'(1 << k), 3, 8'(k << 4),
                  3'(k + 1), 1, 0);
        end
        trial(EV_CAS_RANK_HI, 8'h80, 3, 8'h70, 3'd6, 2, 2);
        $display("test events done");
        // counter wrap raises status, mask gates the interrupt
        axi_wr(ADDR_CTL_BASE, 32'h0040_0102, r);
        axi_wr(ADDR_CNT_BASE, 32'hFFFF_FFFF, r);
        memctl_sched_model_inst.issue(0, 8'h01, 0, 1);
        repeat (3) @(posedge aclk);
        axi_rd(ADDR_INT_STATUS, v, r);
        chk(v, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        axi_wr(ADDR_INT_MASK, 32'h0000_0001, r);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0001);
        axi_wr(ADDR_INT_STATUS, 32'h0000_0001, r);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test interrupt done");
        conclude();
    end

    initial begin
        #(25ns * 20000);
        mismatches++;
        conclude();
    end
endmodule : tb_top
